// ==== src/dot_memory.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "lcd_cfg.svh"

module dot_memory (
   input  wire logic                      clock,
   input  wire logic                      srst,
   input  wire logic                      wr,
   input  wire logic [7:0]                addr,
   input  wire logic [7:0]                wdata,
   output logic      [7:0]                rd_data,
   input  wire logic [`LCD_COM_W-1:0]     row_sel,
   output logic      [`LCD_NUM_SEG-1:0]   row_segs
);

   // ----------------------------------------
   // 32 rows of 8 bytes
   // ----------------------------------------
   logic [7:0] mem [0:255];

   // cleared on reset so a freshly enabled panel shows blank, not garbage
   always_ff @(posedge clock) begin
      if (srst) begin
         for (int i = 0; i < 256; i++) begin
            mem[i] <= 8'h00;
         end
      end else if (wr) begin
         mem[addr] <= wdata;
      end
   end

   assign rd_data = mem[addr];

   // byte 7 of each row is storage only, never scanned
   always_comb begin
      row_segs = '0;
      for (int b = 0; b < `LCD_SEG_BYTES; b++) begin
         row_segs[b*8 +: 8] = mem[{row_sel, 3'(b)}];
      end
   end

endmodule // dot_memory

`default_nettype wire

// ==== src/frame_timer.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "lcd_cfg.svh"

module frame_timer
   import lcd_pkg::*;
#(
   parameter frame_alternation_freq_sel_t FREQ_OPTION = FRAME_ALTERNATION_FREQ_16HZ
) (
   input  wire logic   clock,
   input  wire logic   srst,
   input  wire logic   sub_osc_in,
   input  wire logic   enable,
   lcd_scan_if.timer   scan
);

   localparam logic [`LCD_SLOT_W-1:0] SLOT_LAST =
      `LCD_SLOT_W'((`LCD_SLOT_EDGES >> FREQ_OPTION) - 1);

   scan_state_t           state_reg,  state_next;
   logic                  osc_prev_reg, osc_prev_next;
   logic [`LCD_SLOT_W-1:0] slot_reg,  slot_next;
   logic [`LCD_COM_W-1:0] com_reg,    com_next;
   logic                  phase_reg,  phase_next;
   logic                  tick_reg,   tick_next;
   logic                  osc_rise;

   // ----------------------------------------
   // sub-oscillator divide chain
   // ----------------------------------------
   always_comb begin
      osc_prev_next = sub_osc_in;
      osc_rise      = sub_osc_in & ~osc_prev_reg;
      state_next    = state_reg;
      slot_next     = slot_reg;
      com_next      = com_reg;
      phase_next    = phase_reg;
      tick_next     = 1'b0;
      case (state_reg)
         SCAN_IDLE: begin
            slot_next  = '0;
            com_next   = '0;
            phase_next = 1'b0;
            if (enable) begin
               state_next = SCAN_RUN;
            end
         end
         SCAN_RUN: begin
            if (!enable) begin
               state_next = SCAN_IDLE;
            end else if (osc_rise) begin
               if (slot_reg == SLOT_LAST) begin
                  slot_next = '0;
                  tick_next = 1'b1;
                  com_next  = com_reg + 1'b1;
                  // polarity flips once per full scan of the commons
                  if (com_reg == `LCD_COM_W'(`LCD_NUM_COM - 1)) begin
                     phase_next = ~phase_reg;
                  end
               end else begin
                  slot_next = slot_reg + 1'b1;
               end
            end
         end
         default: state_next = SCAN_IDLE;
      endcase
   end

   always_ff @(posedge clock) begin
      if (srst) begin
         state_reg    <= SCAN_IDLE;
         osc_prev_reg <= 1'b0;
         slot_reg     <= '0;
         com_reg      <= '0;
         phase_reg    <= 1'b0;
         tick_reg     <= 1'b0;
      end else begin
         state_reg    <= state_next;
         osc_prev_reg <= osc_prev_next;
         slot_reg     <= slot_next;
         com_reg      <= com_next;
         phase_reg    <= phase_next;
         tick_reg     <= tick_next;
      end
   end

   assign scan.com_tick    = tick_reg;
   assign scan.com_index   = com_reg;
   assign scan.frame_phase = phase_reg;

endmodule // frame_timer

`default_nettype wire

// ==== src/lcd_cfg.svh ====
`ifndef LCD_CFG_SVH
`define LCD_CFG_SVH

// ----------------------------------------
// panel geometry
// ----------------------------------------
`define LCD_NUM_SEG        56
`define LCD_NUM_COM        32
`define LCD_DOTS           1792
`define LCD_BIAS_DEN       5
`define LCD_SEG_BYTES      7
`define LCD_COM_W          5

// ----------------------------------------
// register map
// ----------------------------------------
`define LCD_MEM_PAGE       8'h20
`define LCD_REG_CTRL       16'h0010
`define LCD_REG_TRIM       16'h0011
`define LCD_REG_STATUS     16'h0012
`define LCD_CTRL_ON_BIT    6
`define LCD_TRIM_RESET     4'hA
`define LCD_STAT_PUMP_BIT  0
`define LCD_STAT_PHASE_BIT 1
`define LCD_STAT_ACT_BIT   2
`define LCD_STAT_COM_LSB   3

// ----------------------------------------
// frame timing, in sub-oscillator edges
// ----------------------------------------
`define LCD_SUB_OSCILLATOR_FREQ_HZ 32768
`define LCD_FRAME_ALTERNATION_FREQ_MIN_HZ    16
`define LCD_SLOT_EDGES     (`LCD_SUB_OSCILLATOR_FREQ_HZ / (`LCD_FRAME_ALTERNATION_FREQ_MIN_HZ * `LCD_NUM_COM))
`define LCD_SLOT_W         7

// ----------------------------------------
// drive levels, vk = vlcd * (5 - k) / 5
// ----------------------------------------
`define LCD_V0             3'h0
`define LCD_V1             3'h1
`define LCD_V2             3'h2
`define LCD_V3             3'h3
`define LCD_V4             3'h4
`define LCD_V5             3'h5

`endif

// ==== src/lcd_pkg.sv ====
`default_nettype none

package lcd_pkg;

   typedef logic [2:0] level_t;

   typedef enum logic [1:0] {
      FRAME_ALTERNATION_FREQ_16HZ  = 2'b00,
      FRAME_ALTERNATION_FREQ_32HZ  = 2'b01,
      FRAME_ALTERNATION_FREQ_64HZ  = 2'b10,
      FRAME_ALTERNATION_FREQ_128HZ = 2'b11
   } frame_alternation_freq_sel_t;

   typedef enum logic {
      SCAN_IDLE = 1'b0,
      SCAN_RUN  = 1'b1
   } scan_state_t;

endpackage

`default_nettype wire

// ==== src/lcd_scan_if.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "lcd_cfg.svh"

interface lcd_scan_if;
   logic                    com_tick;
   logic [`LCD_COM_W-1:0]   com_index;
   logic                    frame_phase;

   modport timer (output com_tick, output com_index, output frame_phase);
   modport core  (input com_tick, input com_index, input frame_phase);
endinterface

`default_nettype wire

// ==== src/segment_lcd_driver.sv ====
// Our own choices: the placing of the registers and strobed register access.
`timescale 1ns/1ps
`default_nettype none
`include "lcd_cfg.svh"

module segment_lcd_driver
   import lcd_pkg::*;
#(
   parameter logic      PUMP_OPTION = 1'b1,
   parameter frame_alternation_freq_sel_t FREQ_OPTION = FRAME_ALTERNATION_FREQ_16HZ
) (
   input  wire logic                          clock,
   input  wire logic                          srst,
   input  wire logic                          sub_osc_in,
   input  wire logic [15:0]                   addr,
   input  wire logic [7:0]                    wdata,
   input  wire logic                          wr,
   input  wire logic                          rd,
   output logic      [7:0]                    rdata,
   output logic                               pump_run,
   output logic      [3:0]                    regulator_trim,
   output level_t    [`LCD_NUM_COM-1:0]       com_level,
   output level_t    [`LCD_NUM_SEG-1:0]       seg_level
);

   // ----------------------------------------
   // declarations
   // ----------------------------------------
   logic                         display_on_reg,  display_on_next;
   logic [3:0]                   trim_reg,        trim_next;
   logic                         pump_reg,        pump_next;
   logic [7:0]                   rdata_reg,       rdata_next;
   level_t [`LCD_NUM_COM-1:0]    com_reg,         com_next;
   level_t [`LCD_NUM_SEG-1:0]    seg_reg,         seg_next;

   logic                         sel_ctrl;
   logic                         sel_trim;
   logic                         sel_status;
   logic                         sel_mem;
   logic                         mem_wr;
   logic [7:0]                   mem_rd_data;
   logic [`LCD_NUM_SEG-1:0]      row_segs;
   logic [7:0]                   status_byte;

   lcd_scan_if scan ();

   // ----------------------------------------
   // sub-blocks
   // ----------------------------------------
   frame_timer #(
      .FREQ_OPTION (FREQ_OPTION)
   ) u_frame_timer (
      .clock      (clock),
      .srst       (srst),
      .sub_osc_in (sub_osc_in),
      .enable     (display_on_reg),
      .scan       (scan)
   );

   dot_memory u_dot_memory (
      .clock    (clock),
      .srst     (srst),
      .wr       (mem_wr),
      .addr     (addr[7:0]),
      .wdata    (wdata),
      .rd_data  (mem_rd_data),
      .row_sel  (scan.com_index),
      .row_segs (row_segs)
   );

   // ----------------------------------------
   // address decode
   // ----------------------------------------
   always_comb begin
      sel_ctrl   = 1'b0;
      sel_trim   = 1'b0;
      sel_status = 1'b0;
      sel_mem    = 1'b0;
      if (addr[15:8] == `LCD_MEM_PAGE) begin
         sel_mem = 1'b1;
      end else if (addr == `LCD_REG_CTRL) begin
         sel_ctrl = 1'b1;
      end else if (addr == `LCD_REG_TRIM) begin
         sel_trim = 1'b1;
      end else if (addr == `LCD_REG_STATUS) begin
         sel_status = 1'b1;
      end
   end

   assign mem_wr = wr & sel_mem;

   // ----------------------------------------
   // control registers
   // ----------------------------------------
   always_comb begin
      display_on_next = display_on_reg;
      trim_next       = trim_reg;
      if (wr && sel_ctrl) begin
         display_on_next = wdata[`LCD_CTRL_ON_BIT];
      end
      if (wr && sel_trim) begin
         // analog side: larger code, lower regulator voltage, less contrast
         trim_next = wdata[3:0];
      end
   end

   // pump only exists when built in; the on bit can never conjure it
   always_comb begin
      pump_next = PUMP_OPTION & display_on_reg;
   end

   always_ff @(posedge clock) begin
      if (srst) begin
         display_on_reg <= 1'b0;
         trim_reg       <= `LCD_TRIM_RESET;
         pump_reg       <= 1'b0;
      end else begin
         display_on_reg <= display_on_next;
         trim_reg       <= trim_next;
         pump_reg       <= pump_next;
      end
   end

   // ----------------------------------------
   // read path
   // ----------------------------------------
   always_comb begin
      status_byte                      = 8'h00;
      status_byte[`LCD_STAT_PUMP_BIT]  = pump_reg;
      status_byte[`LCD_STAT_PHASE_BIT] = scan.frame_phase;
      status_byte[`LCD_STAT_ACT_BIT]   = display_on_reg;
      status_byte[`LCD_STAT_COM_LSB +: `LCD_COM_W] = scan.com_index;
   end

   always_comb begin
      rdata_next = 8'h00;
      if (rd) begin
         if (sel_mem) begin
            rdata_next = mem_rd_data;
         end else if (sel_ctrl) begin
            rdata_next[`LCD_CTRL_ON_BIT] = display_on_reg;
         end else if (sel_trim) begin
            rdata_next = {4'h0, trim_reg};
         end else if (sel_status) begin
            rdata_next = status_byte;
         end
      end
   end

   always_ff @(posedge clock) begin
      if (srst) begin
         rdata_reg <= 8'h00;
      end else begin
         rdata_reg <= rdata_next;
      end
   end

   // ----------------------------------------
   // common waveforms
   // ----------------------------------------
   // display off parks every line at v5 so no dc sits across the glass
   always_comb begin
      for (int c = 0; c < `LCD_NUM_COM; c++) begin
         if (!display_on_reg) begin
            com_next[c] = `LCD_V5;
         end else if (scan.com_index == `LCD_COM_W'(c)) begin
            com_next[c] = scan.frame_phase ? `LCD_V5 : `LCD_V0;
         end else begin
            com_next[c] = scan.frame_phase ? `LCD_V1 : `LCD_V4;
         end
      end
   end

   // ----------------------------------------
   // segment waveforms
   // ----------------------------------------
   // row data is read live, so a memory write shows within two cycles
   always_comb begin
      for (int s = 0; s < `LCD_NUM_SEG; s++) begin
         if (!display_on_reg) begin
            seg_next[s] = `LCD_V5;
         end else if (row_segs[s]) begin
            seg_next[s] = scan.frame_phase ? `LCD_V0 : `LCD_V5;
         end else begin
            seg_next[s] = scan.frame_phase ? `LCD_V2 : `LCD_V3;
         end
      end
   end

   always_ff @(posedge clock) begin
      if (srst) begin
         for (int c = 0; c < `LCD_NUM_COM; c++) begin
            com_reg[c] <= `LCD_V5;
         end
         for (int s = 0; s < `LCD_NUM_SEG; s++) begin
            seg_reg[s] <= `LCD_V5;
         end
      end else begin
         com_reg <= com_next;
         seg_reg <= seg_next;
      end
   end

   // ----------------------------------------
   // outputs
   // ----------------------------------------
   assign rdata          = rdata_reg;
   assign pump_run       = pump_reg;
   assign regulator_trim = trim_reg;
   assign com_level      = com_reg;
   assign seg_level      = seg_reg;

endmodule // segment_lcd_driver

`default_nettype wire

// ==== tb/lcd_panel_model.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "lcd_cfg.svh"

// ----------------------------------------
// glass panel: finds the selected common and lit dots
// ----------------------------------------
module lcd_panel_model
   import lcd_pkg::*;
(
   input  wire level_t [`LCD_NUM_COM-1:0] com_level,
   input  wire level_t [`LCD_NUM_SEG-1:0] seg_level,
   output logic [4:0]                     sel_com,
   output logic                           sel_ok,
   output logic                           phase,
   output logic [`LCD_NUM_SEG-1:0]        lit
);
   int n0;
   int n5;
   int i0;
   int i5;

   always_comb begin
      n0 = 0;
      n5 = 0;
      i0 = 0;
      i5 = 0;
      for (int c = 0; c < `LCD_NUM_COM; c++) begin
         if (com_level[c] == `LCD_V0) begin
            n0++;
            i0 = c;
         end
         if (com_level[c] == `LCD_V5) begin
            n5++;
            i5 = c;
         end
      end
      // one common at a rail, the rest at the inner levels
      sel_ok  = (n0 == 1 && n5 == 0) || (n5 == 1 && n0 == 0);
      phase   = (n0 != 1);
      sel_com = phase ? 5'(i5) : 5'(i0);
      // only the full five-step swing across a cell turns it on
      for (int s = 0; s < `LCD_NUM_SEG; s++)
         lit[s] = sel_ok && seg_level[s] == (phase ? `LCD_V0 : `LCD_V5);
   end
endmodule // lcd_panel_model

`default_nettype wire

// ==== tb/segment_lcd_driver_bench.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "lcd_cfg.svh"

module segment_lcd_driver_bench
   import lcd_pkg::*;
;
   // 128Hz option: 8 sub edges per common, test sub clock edge every 8 cycles
   localparam int SLOT = (32768 / (128 * 32)) * 8;
   logic                      clock = 1'b0;
   logic                      srst = 1'b1;
   logic                      sub_osc_in = 1'b0;
   logic [15:0]               addr = 16'h0000;
   logic [7:0]                wdata = 8'h00;
   logic                      wr = 1'b0;
   logic                      rd = 1'b0;
   logic [7:0]                rdata;
   logic                      pump_run;
   logic [3:0]                regulator_trim;
   level_t [`LCD_NUM_COM-1:0] com_level;
   level_t [`LCD_NUM_SEG-1:0] seg_level;
   logic [4:0]                sel_com;
   logic [4:0]                prev;
   logic                      sel_ok;
   logic                      phase;
   logic [`LCD_NUM_SEG-1:0]   lit;
   // second build: no pump, slowest frame option
   logic                      pump_run_np;
   level_t [`LCD_NUM_COM-1:0] com_level_np;
   level_t [`LCD_NUM_SEG-1:0] seg_level_np;
   logic [4:0]                sel_com_np;
   logic                      sel_ok_np;
   logic                      phase_np;
   logic [`LCD_NUM_SEG-1:0]   lit_np;
   logic [2:0]                sub_div = 3'h0;
   logic [15:0]               lfsr = 16'h3F97;
   logic [7:0]                mem_model [0:255];
   logic [7:0]                rv;
   int                        num_errors = 0;
   int                        compares = 0;
   int                        cyc = 0;
   int                        last;

   segment_lcd_driver #(.PUMP_OPTION(1'b1), .FREQ_OPTION(FRAME_ALTERNATION_FREQ_128HZ)) i_dut (
      .clock(clock), .srst(srst), .sub_osc_in(sub_osc_in), .addr(addr), .wdata(wdata),
      .wr(wr), .rd(rd), .rdata(rdata), .pump_run(pump_run), .regulator_trim(regulator_trim),
      .com_level(com_level), .seg_level(seg_level));
   lcd_panel_model i_panel (.com_level(com_level), .seg_level(seg_level), .sel_com(sel_com),
      .sel_ok(sel_ok), .phase(phase), .lit(lit));
   segment_lcd_driver #(.PUMP_OPTION(1'b0), .FREQ_OPTION(FRAME_ALTERNATION_FREQ_16HZ)) i_dut_np (
      .clock(clock), .srst(srst), .sub_osc_in(sub_osc_in), .addr(addr), .wdata(wdata),
      .wr(wr), .rd(rd), .rdata(), .pump_run(pump_run_np), .regulator_trim(),
      .com_level(com_level_np), .seg_level(seg_level_np));
   lcd_panel_model i_panel_np (.com_level(com_level_np), .seg_level(seg_level_np),
      .sel_com(sel_com_np), .sel_ok(sel_ok_np), .phase(phase_np), .lit(lit_np));

   always #12.5 clock = ~clock;

   // ----------------------------------------
   // sub-oscillator stand-in, sped up to keep the run short
   // ----------------------------------------
   always @(posedge clock) begin
      sub_div <= sub_div + 3'h1;
      sub_osc_in <= sub_div[2];
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         num_errors++;
         end_sim();
      end
   end

   function automatic logic [15:0] lfsr_next(input logic [15:0] x);
      return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
   endfunction

   function automatic logic [55:0] exp_row(input logic [4:0] n);
      logic [55:0] r;
      for (int b = 0; b < 7; b++) r[b*8 +: 8] = mem_model[{n, 3'(b)}];
      return r;
   endfunction

   task automatic chk(input logic [63:0] got, input logic [63:0] exp);
      compares++;
      if (got !== exp) begin
         num_errors++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic bus_wr(input logic [15:0] a, input logic [7:0] d);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clock);
      wr <= 1'b0;
      @(posedge clock);
   endtask

   task automatic bus_rd(input logic [15:0] a, output logic [7:0] d);
      addr <= a;
      rd <= 1'b1;
      @(posedge clock);
      rd <= 1'b0;
      #1 d = rdata;
      @(posedge clock);
   endtask

   task automatic end_sim;
      $display("compares %0d errors %0d", compares, num_errors);
      if (num_errors == 0 && compares > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask

   initial begin
      repeat (5) @(posedge clock);
      srst <= 1'b0;
      @(posedge clock);
      #1 chk(regulator_trim, 4'hA);
      chk(pump_run, 1'b0);
      // row 0 all lit, row 31 all dark, byte 7 filled with noise
      for (int i = 0; i < 256; i++) begin
         lfsr = lfsr_next(lfsr);
         mem_model[i] = (i < 8) ? 8'hFF : (i >= 248) ? 8'h00 : lfsr[7:0];
         bus_wr(16'h2000 + 16'(i), mem_model[i]);
      end
      for (int i = 0; i < 256; i++) begin
         bus_rd(16'h2000 + 16'(i), rv);
         chk(rv, mem_model[i]);
      end
      bus_rd(16'h0155, rv);
      chk(rv, 8'h00);
      for (int i = 0; i < 17; i++) begin
         lfsr = lfsr_next(lfsr);
         bus_wr(16'h0011, {lfsr[7:4], (i == 16) ? 4'hA : 4'(i)});
         chk(regulator_trim, (i == 16) ? 4'hA : 4'(i));
      end
      bus_wr(16'h0010, 8'h40);
      repeat (2) @(posedge clock);
      #1 chk(pump_run, 1'b1);
      chk({sel_ok, phase, sel_com}, {2'b10, 5'h00});
      chk(lit, exp_row(5'h00));
      last = cyc;
      // two frames: both polarities, every common once each
      for (int k = 1; k < 65; k++) begin
         prev = sel_com;
         for (int t = 0; t < 2 * SLOT && sel_com === prev; t++) begin
            @(posedge clock);
            #1;
         end
         if (k > 1) chk(cyc - last, SLOT);
         last = cyc;
         repeat (3) @(posedge clock);
         #1 chk({sel_ok, phase, sel_com}, {1'b1, k[5], 5'(k)});
         chk(lit, exp_row(5'(k)));
      end
      bus_rd(16'h0012, rv);
      chk({rv[2], rv[0]}, 2'b11);
      bus_rd(16'h0010, rv);
      chk(rv, 8'h40);
      #1 chk(pump_run_np, 1'b0);
      chk(sel_ok_np, 1'b1);
      chk(lit_np, exp_row(sel_com_np));
      @(posedge clock);
      bus_wr(16'h0010, 8'h00);
      repeat (2) @(posedge clock);
      #1 chk(pump_run, 1'b0);
      chk(com_level === {`LCD_NUM_COM{`LCD_V5}}, 1'b1);
      chk(seg_level === {`LCD_NUM_SEG{`LCD_V5}}, 1'b1);
      end_sim();
   end
endmodule // segment_lcd_driver_bench

bind segment_lcd_driver segment_lcd_driver_monitor #(.PUMP_OPTION(PUMP_OPTION)) i_mon (
   .clock(clock), .srst(srst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
   .pump_run(pump_run), .regulator_trim(regulator_trim), .com_level(com_level),
   .seg_level(seg_level));

`default_nettype wire

// ==== tb/segment_lcd_driver_monitor.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "lcd_cfg.svh"

module segment_lcd_driver_monitor
   import lcd_pkg::*;
#(
   parameter logic PUMP_OPTION = 1'b1
) (
   input wire logic                      clock,
   input wire logic                      srst,
   input wire logic [15:0]               addr,
   input wire logic [7:0]                wdata,
   input wire logic                      wr,
   input wire logic                      rd,
   input wire logic [7:0]                rdata,
   input wire logic                      pump_run,
   input wire logic [3:0]                regulator_trim,
   input wire level_t [`LCD_NUM_COM-1:0] com_level,
   input wire level_t [`LCD_NUM_SEG-1:0] seg_level
);
   logic       all_v5;
   logic       bad_level;
   logic [5:0] sel_count;

   always_comb begin
      all_v5    = 1'b1;
      bad_level = 1'b0;
      sel_count = 6'h00;
      for (int c = 0; c < `LCD_NUM_COM; c++) begin
         if (com_level[c] != `LCD_V5) all_v5 = 1'b0;
         if (com_level[c] == `LCD_V0 || com_level[c] == `LCD_V5) sel_count = sel_count + 6'h01;
         if (com_level[c] == `LCD_V2 || com_level[c] == `LCD_V3 || com_level[c] > `LCD_V5)
            bad_level = 1'b1;
      end
      for (int s = 0; s < `LCD_NUM_SEG; s++) begin
         if (seg_level[s] != `LCD_V5) all_v5 = 1'b0;
         if (seg_level[s] == `LCD_V1 || seg_level[s] == `LCD_V4 || seg_level[s] > `LCD_V5)
            bad_level = 1'b1;
      end
   end

   default clocking cb @(posedge clock); endclocking
   default disable iff (srst);

   AST_RD_IDLE: assert property (!rd |=> rdata == 8'h00)
      else $error("read data not zero outside a read");
   AST_UNMAPPED: assert property (rd && addr[15:8] == 8'h01 |=> rdata == 8'h00)
      else $error("unmapped read not zero");
   AST_TRIM_WR: assert property (
      wr && addr == 16'h0011 |=> {4'h0, regulator_trim} == ($past(wdata) & 8'h0F))
      else $error("trim code not taken");
   AST_TRIM_HOLD: assert property (!(wr && addr == 16'h0011) |=> $stable(regulator_trim))
      else $error("trim code moved without write");
   AST_TRIM_RD: assert property (
      rd && addr == 16'h0011 |=> rdata[3:0] == $past(regulator_trim))
      else $error("trim readback wrong");
   AST_STAT_RD: assert property (rd && addr == 16'h0012 |=> rdata[0] == $past(pump_run))
      else $error("status pump bit wrong");
   AST_PUMP_ON: assert property (
      wr && addr == 16'h0010 && wdata[6] |-> ##2 pump_run == PUMP_OPTION)
      else $error("pump state wrong after display on");
   AST_PUMP_OFF: assert property (
      wr && addr == 16'h0010 && !wdata[6] |-> ##2 !pump_run)
      else $error("pump still running after display off");
   AST_BLANK: assert property (PUMP_OPTION && $stable(pump_run) |-> all_v5 == !pump_run)
      else $error("blanking does not follow pump");
   AST_LEVELS: assert property (!bad_level)
      else $error("illegal drive level");
   AST_ONE_SEL: assert property (pump_run && $past(pump_run) |-> sel_count == 6'h01)
      else $error("not exactly one common selected");
endmodule // segment_lcd_driver_monitor

`default_nettype wire
